// ---- sfe_map.svh ----
// Offsets, opcodes, field positions and reset values of the SPI command front end.
// Assumes inclusion by its bare name from the front end's design files.
`ifndef SFE_MAP_SVH
`define SFE_MAP_SVH

// Positions of the pins in the synchroniser vector, and the vector's reset value
`define SFE_PIN_CS        0
`define SFE_PIN_SCK       1
`define SFE_PIN_SI        2
`define SFE_PIN_HOLD      3
`define SFE_PIN_RST       4'hF

// Opcodes
`define SFE_OP_RD_FAST    8'h0B
`define SFE_OP_RD_SLOW    8'h03
`define SFE_OP_ERASE_4K   8'h20
`define SFE_OP_ERASE_32A  8'h52
`define SFE_OP_ERASE_32B  8'hD8
`define SFE_OP_CHIP_A     8'h60
`define SFE_OP_CHIP_B     8'hC7
`define SFE_OP_CHIP_OLD   8'h62
`define SFE_OP_PROGRAM    8'h02
`define SFE_OP_WR_EN      8'h06
`define SFE_OP_WR_DIS     8'h04
`define SFE_OP_OTP_PROG   8'h9B
`define SFE_OP_OTP_READ   8'h77
`define SFE_OP_STAT_RD    8'h05
`define SFE_OP_STAT_WR    8'h01
`define SFE_OP_ID         8'h9F
`define SFE_OP_ID_OLD     8'h15
`define SFE_OP_PWR_DOWN   8'hB9
`define SFE_OP_PWR_UP     8'hAB

// Phase lengths in bytes
`define SFE_ADDR_BYTES    2'h3
`define SFE_NO_BYTES      2'h0
`define SFE_ONE_BYTE      2'h1
`define SFE_TWO_BYTES     2'h2
`define SFE_OUT_ANY       3'h0
`define SFE_ID_OLD_BYTES  3'h2

// Region masks applied to the captured address, and the byte sent when no data is offered
`define SFE_MASK_4K       16'hF000
`define SFE_MASK_32K      16'h8000
`define SFE_MASK_PAGE     16'hFFFF
`define SFE_IDLE_BYTE     8'hFF

`endif

// ---- sfe_pkg.sv ----
// Types shared by the SPI command front end.
// Assumes nothing of its surroundings.
`default_nettype none
package sfe_pkg;

  typedef enum logic [3:0] {
    SFE_CMD_NONE, SFE_CMD_READ, SFE_CMD_ERASE_4K, SFE_CMD_ERASE_32K, SFE_CMD_ERASE_CHIP,
    SFE_CMD_PROGRAM, SFE_CMD_WR_EN, SFE_CMD_WR_DIS, SFE_CMD_OTP_PROG, SFE_CMD_OTP_READ,
    SFE_CMD_STAT_RD, SFE_CMD_STAT_WR, SFE_CMD_ID, SFE_CMD_ID_OLD, SFE_CMD_PWR_DOWN,
    SFE_CMD_PWR_UP
  } sfe_cmd_t;

  typedef enum logic [1:0] {SFE_DIR_NONE, SFE_DIR_IN, SFE_DIR_OUT} sfe_dir_t;

  typedef struct packed {
    sfe_cmd_t   cmd;
    logic       known;
    logic [1:0] addr_n;
    logic [1:0] dummy_n;
    sfe_dir_t   dir;
    logic [2:0] out_max;
  } sfe_op_t;

endpackage : sfe_pkg

`default_nettype wire

// ---- sfe_buf.sv ----
// Small ring buffer with valid/ready on both sides.
// Assumes one clock; the reader may stall and the writer sees in_ready_o fall.
`timescale 1ns/100ps
`default_nettype none

module sfe_buf #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clk_sys_i,   // System clock
  input  wire logic             rst_b_i,     // Asynchronous reset, active low
  input  wire logic [WIDTH-1:0] in_data_i,   // Word to store
  input  wire logic             in_valid_i,  // Word offered
  output logic                  in_ready_o,  // Room for a word
  output logic      [WIDTH-1:0] out_data_o,  // Oldest word
  output logic                  out_valid_o, // Oldest word present
  input  wire logic             out_ready_i  // Reader takes the word
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0) || (WIDTH < 1)) begin : g_bad
      $error("sfe_buf: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) mem_reg[wr_ptr_reg] <= in_data_i;
  end

endmodule : sfe_buf

`default_nettype wire

// ---- sfe_spi_front_end.sv ----
// SPI-slave command front end of a small serial flash: framing, opcode decode, data paths.
// Assumes the serial pins arrive asynchronously and SCK is at least eight clk_sys_i periods.
`timescale 1ns/100ps
`default_nettype none
`include "sfe_map.svh"

module sfe_spi_front_end #(
  parameter int unsigned ID_MAX_BYTES = 4
) (
  input  wire logic              clk_sys_i,     // System clock, 20 MHz
  input  wire logic              rst_b_i,       // Asynchronous reset, active low
  input  wire logic              cs_b_i,        // Chip select pin, active low
  input  wire logic              sck_i,         // Serial clock pin
  input  wire logic              si_i,          // Serial input pin
  input  wire logic              hold_b_i,      // Hold pin, active low
  output logic                   so_o,          // Serial output level
  output logic                   so_oe_o,       // Serial output enable
  output sfe_pkg::sfe_cmd_t      cmd_code_o,    // Decoded command
  output logic [15:0]            cmd_addr_o,    // Region-aligned address
  output logic                   cmd_start_o,   // Header complete pulse
  output logic                   cmd_commit_o,  // Command complete pulse
  output logic                   cmd_abort_o,   // Command discarded pulse
  output logic [7:0]             rx_data_o,     // Received data byte
  output logic                   rx_valid_o,    // Received byte waiting
  input  wire logic              rx_ready_i,    // Receiver takes the byte
  output logic                   rx_overrun_o,  // Byte lost this frame
  input  wire logic [7:0]        tx_data_i,     // Byte to send
  input  wire logic              tx_valid_i,    // Byte to send present
  output logic                   tx_ready_o     // Byte to send taken
);

  generate
    if ((ID_MAX_BYTES < 1) || (ID_MAX_BYTES > 7)) begin : g_bad
      $error("sfe_spi_front_end: ID_MAX_BYTES must be 1 to 7");
    end
  endgenerate

  typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_HDR, ST_DATA, ST_IGNORE} sfe_state_t;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic sfe_pkg::sfe_op_t op_mk(input sfe_pkg::sfe_cmd_t c,
                                             input logic [1:0] a,
                                             input logic [1:0] dm,
                                             input sfe_pkg::sfe_dir_t dir,
                                             input logic [2:0] mx);
    sfe_pkg::sfe_op_t o;
    o.cmd     = c;
    o.known   = 1'b1;
    o.addr_n  = a;
    o.dummy_n = dm;
    o.dir     = dir;
    o.out_max = mx;
    return o;
  endfunction : op_mk

  function automatic sfe_pkg::sfe_op_t op_decode(input logic [7:0] op);
    sfe_pkg::sfe_op_t d;
    d = op_mk(sfe_pkg::SFE_CMD_NONE, `SFE_NO_BYTES, `SFE_NO_BYTES, sfe_pkg::SFE_DIR_NONE,
              `SFE_OUT_ANY);
    d.known = 1'b0;
    case (op)
      `SFE_OP_RD_FAST: d = op_mk(sfe_pkg::SFE_CMD_READ, `SFE_ADDR_BYTES, `SFE_ONE_BYTE,
                                 sfe_pkg::SFE_DIR_OUT, `SFE_OUT_ANY);
      `SFE_OP_RD_SLOW: d = op_mk(sfe_pkg::SFE_CMD_READ, `SFE_ADDR_BYTES, `SFE_NO_BYTES,
                                 sfe_pkg::SFE_DIR_OUT, `SFE_OUT_ANY);
      `SFE_OP_ERASE_4K: d = op_mk(sfe_pkg::SFE_CMD_ERASE_4K, `SFE_ADDR_BYTES, `SFE_NO_BYTES,
                                  sfe_pkg::SFE_DIR_NONE, `SFE_OUT_ANY);
      `SFE_OP_ERASE_32A,
      `SFE_OP_ERASE_32B: d = op_mk(sfe_pkg::SFE_CMD_ERASE_32K, `SFE_ADDR_BYTES, `SFE_NO_BYTES,
                                   sfe_pkg::SFE_DIR_NONE, `SFE_OUT_ANY);
      `SFE_OP_CHIP_A,
      `SFE_OP_CHIP_B,
      `SFE_OP_CHIP_OLD: d = op_mk(sfe_pkg::SFE_CMD_ERASE_CHIP, `SFE_NO_BYTES, `SFE_NO_BYTES,
                                  sfe_pkg::SFE_DIR_NONE, `SFE_OUT_ANY);
      `SFE_OP_PROGRAM: d = op_mk(sfe_pkg::SFE_CMD_PROGRAM, `SFE_ADDR_BYTES, `SFE_NO_BYTES,
                                 sfe_pkg::SFE_DIR_IN, `SFE_OUT_ANY);
      `SFE_OP_WR_EN: d = op_mk(sfe_pkg::SFE_CMD_WR_EN, `SFE_NO_BYTES, `SFE_NO_BYTES,
                               sfe_pkg::SFE_DIR_NONE, `SFE_OUT_ANY);
      `SFE_OP_WR_DIS: d = op_mk(sfe_pkg::SFE_CMD_WR_DIS, `SFE_NO_BYTES, `SFE_NO_BYTES,
                                sfe_pkg::SFE_DIR_NONE, `SFE_OUT_ANY);
      `SFE_OP_OTP_PROG: d = op_mk(sfe_pkg::SFE_CMD_OTP_PROG, `SFE_ADDR_BYTES, `SFE_NO_BYTES,
                                  sfe_pkg::SFE_DIR_IN, `SFE_OUT_ANY);
      `SFE_OP_OTP_READ: d = op_mk(sfe_pkg::SFE_CMD_OTP_READ, `SFE_ADDR_BYTES, `SFE_TWO_BYTES,
                                  sfe_pkg::SFE_DIR_OUT, `SFE_OUT_ANY);
      `SFE_OP_STAT_RD: d = op_mk(sfe_pkg::SFE_CMD_STAT_RD, `SFE_NO_BYTES, `SFE_NO_BYTES,
                                 sfe_pkg::SFE_DIR_OUT, `SFE_OUT_ANY);
      `SFE_OP_STAT_WR: d = op_mk(sfe_pkg::SFE_CMD_STAT_WR, `SFE_NO_BYTES, `SFE_NO_BYTES,
                                 sfe_pkg::SFE_DIR_IN, `SFE_OUT_ANY);
      `SFE_OP_ID: d = op_mk(sfe_pkg::SFE_CMD_ID, `SFE_NO_BYTES, `SFE_NO_BYTES,
                            sfe_pkg::SFE_DIR_OUT, 3'(ID_MAX_BYTES));
      `SFE_OP_ID_OLD: d = op_mk(sfe_pkg::SFE_CMD_ID_OLD, `SFE_NO_BYTES, `SFE_NO_BYTES,
                                sfe_pkg::SFE_DIR_OUT, `SFE_ID_OLD_BYTES);
      `SFE_OP_PWR_DOWN: d = op_mk(sfe_pkg::SFE_CMD_PWR_DOWN, `SFE_NO_BYTES, `SFE_NO_BYTES,
                                  sfe_pkg::SFE_DIR_NONE, `SFE_OUT_ANY);
      `SFE_OP_PWR_UP: d = op_mk(sfe_pkg::SFE_CMD_PWR_UP, `SFE_NO_BYTES, `SFE_NO_BYTES,
                                sfe_pkg::SFE_DIR_NONE, `SFE_OUT_ANY);
      default: d.known = 1'b0;
    endcase
    return d;
  endfunction : op_decode

  // The 4K and 32K erases ignore the low bits inside their region; everything else keeps the byte address
  function automatic logic [15:0] addr_align(input sfe_pkg::sfe_cmd_t c, input logic [15:0] a);
    logic [15:0] m;
    m = `SFE_MASK_PAGE;
    if (c == sfe_pkg::SFE_CMD_ERASE_4K) m = `SFE_MASK_4K;
    if (c == sfe_pkg::SFE_CMD_ERASE_32K) m = `SFE_MASK_32K;
    return a & m;
  endfunction : addr_align

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts once stages two and three agree

  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] filt_reg;
  logic [3:0] filt_d_reg;
  wire  [3:0] pins_raw  = {hold_b_i, si_i, sck_i, cs_b_i};
  wire  [3:0] filt_next = (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_reg  <= `SFE_PIN_RST;
      sync2_reg  <= `SFE_PIN_RST;
      sync3_reg  <= `SFE_PIN_RST;
      filt_reg   <= `SFE_PIN_RST;
      filt_d_reg <= `SFE_PIN_RST;
    end else begin
      sync1_reg  <= pins_raw;
      sync2_reg  <= sync1_reg;
      sync3_reg  <= sync2_reg;
      filt_reg   <= filt_next;
      filt_d_reg <= filt_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Edges and phase decode

  sfe_state_t        st_reg;
  sfe_state_t        st_next;
  logic              hold_act_reg;
  logic [2:0]        bit_cnt_reg;
  logic [7:0]        rx_sh_reg;
  sfe_pkg::sfe_op_t  op_reg;
  logic [1:0]        addr_left_reg;
  logic [1:0]        dummy_left_reg;
  logic [15:0]       addr_sh_reg;
  logic [1:0]        din_cnt_reg;
  logic [2:0]        out_cnt_reg;
  logic [7:0]        tx_sh_reg;
  logic              buf_in_ready;

  wire cs_act    = ~filt_reg[`SFE_PIN_CS];
  wire cs_fall   = cs_act & filt_d_reg[`SFE_PIN_CS];
  wire cs_rise   = filt_reg[`SFE_PIN_CS] & ~filt_d_reg[`SFE_PIN_CS];
  // Only edges matter, so the resting level of SCK between frames is irrelevant
  wire sck_rise  = filt_reg[`SFE_PIN_SCK] & ~filt_d_reg[`SFE_PIN_SCK];
  wire sck_fall  = ~filt_reg[`SFE_PIN_SCK] & filt_d_reg[`SFE_PIN_SCK];
  wire si_bit    = filt_reg[`SFE_PIN_SI];
  wire hold_low  = ~filt_reg[`SFE_PIN_HOLD];
  wire sck_low   = ~filt_reg[`SFE_PIN_SCK];
  wire hold_next = cs_act & (hold_act_reg ? ~(~hold_low & sck_low) : (hold_low & sck_low));
  wire listening = (st_reg == ST_OPCODE) | (st_reg == ST_HDR) | (st_reg == ST_DATA);
  wire rise_eff  = sck_rise & cs_act & ~hold_act_reg & listening;
  wire fall_eff  = sck_fall & cs_act & ~hold_act_reg;
  wire byte_done = rise_eff & (bit_cnt_reg == 3'h7);
  wire [7:0] rx_byte = {rx_sh_reg[6:0], si_bit};

  sfe_pkg::sfe_op_t op_dec;
  assign op_dec = op_decode(rx_byte);

  wire opc_byte   = byte_done & (st_reg == ST_OPCODE);
  wire hdr_byte   = byte_done & (st_reg == ST_HDR);
  wire data_byte  = byte_done & (st_reg == ST_DATA);
  wire opc_short  = (op_dec.addr_n == `SFE_NO_BYTES) & (op_dec.dummy_n == `SFE_NO_BYTES);
  wire hdr_last   = (addr_left_reg + {1'b0, (dummy_left_reg != `SFE_NO_BYTES)}) == 2'h1
                    & (dummy_left_reg <= `SFE_ONE_BYTE);
  wire hdr_done   = (opc_byte & op_dec.known & opc_short) | (hdr_byte & hdr_last);
  wire addr_phase = hdr_byte & (addr_left_reg != `SFE_NO_BYTES);
  wire [15:0] addr_now = addr_phase ? {addr_sh_reg[7:0], rx_byte} : addr_sh_reg;

  sfe_pkg::sfe_op_t hdr_op;
  assign hdr_op = (st_reg == ST_OPCODE) ? op_dec : op_reg;

  wire out_dir  = (op_reg.dir == sfe_pkg::SFE_DIR_OUT);
  wire rx_push  = data_byte & (op_reg.dir == sfe_pkg::SFE_DIR_IN);
  wire tx_load  = (hdr_done & (hdr_op.dir == sfe_pkg::SFE_DIR_OUT)) | (data_byte & out_dir);
  wire out_room = (hdr_op.out_max == `SFE_OUT_ANY) | (out_cnt_reg < hdr_op.out_max);
  wire tx_take  = tx_load & out_room;
  wire [7:0] tx_byte = (tx_take & tx_valid_i) ? tx_data_i : `SFE_IDLE_BYTE;

  wire on_byte  = (bit_cnt_reg == 3'h0);
  wire din_ok   = (din_cnt_reg != 2'h0)
                  & ((op_reg.cmd != sfe_pkg::SFE_CMD_STAT_WR) | (din_cnt_reg == 2'h1));
  wire cmd_ok   = (st_reg == ST_DATA) & (out_dir | (on_byte & ((op_reg.dir ==
                  sfe_pkg::SFE_DIR_NONE) | ((op_reg.dir == sfe_pkg::SFE_DIR_IN) & din_ok))));

  assign tx_ready_o = tx_take;
  assign so_oe_o    = cs_act & ~hold_act_reg & (st_reg == ST_DATA) & out_dir;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Command state

  always_comb begin
    st_next = st_reg;
    if (cs_rise) begin
      st_next = ST_IDLE;
    end else if (cs_fall) begin
      st_next = ST_OPCODE;
    end else if (byte_done) begin
      unique case (st_reg)
        ST_OPCODE: st_next = !op_dec.known ? ST_IGNORE : (opc_short ? ST_DATA : ST_HDR);
        ST_HDR:    st_next = hdr_last ? ST_DATA : ST_HDR;
        ST_DATA:   st_next = ST_DATA;
        ST_IDLE:   st_next = ST_IDLE;
        ST_IGNORE: st_next = ST_IGNORE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg       <= ST_IDLE;
      hold_act_reg <= 1'b0;
      bit_cnt_reg  <= 3'h0;
      rx_sh_reg    <= 8'h00;
    end else begin
      st_reg       <= st_next;
      hold_act_reg <= hold_next;
      if (cs_fall) bit_cnt_reg <= 3'h0;
      else if (rise_eff) bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (rise_eff) rx_sh_reg <= rx_byte;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      op_reg         <= '0;
      addr_left_reg  <= 2'h0;
      dummy_left_reg <= 2'h0;
      addr_sh_reg    <= 16'h0000;
    end else if (opc_byte) begin
      op_reg         <= op_dec;
      addr_left_reg  <= op_dec.addr_n;
      dummy_left_reg <= op_dec.dummy_n;
    end else if (hdr_byte) begin
      if (addr_phase) begin
        addr_left_reg <= addr_left_reg - 2'h1;
        addr_sh_reg   <= addr_now;
      end else begin
        dummy_left_reg <= dummy_left_reg - 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // User-side results

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_code_o   <= sfe_pkg::SFE_CMD_NONE;
      cmd_addr_o   <= 16'h0000;
      cmd_start_o  <= 1'b0;
      cmd_commit_o <= 1'b0;
      cmd_abort_o  <= 1'b0;
      rx_overrun_o <= 1'b0;
      din_cnt_reg  <= 2'h0;
    end else begin
      cmd_start_o  <= hdr_done;
      cmd_commit_o <= cs_rise & cmd_ok;
      cmd_abort_o  <= cs_rise & ~cmd_ok & (st_reg != ST_IDLE);
      if (hdr_done) begin
        cmd_code_o <= hdr_op.cmd;
        cmd_addr_o <= addr_align(hdr_op.cmd, addr_now);
      end
      if (cs_fall) rx_overrun_o <= 1'b0;
      else if (rx_push & ~buf_in_ready) rx_overrun_o <= 1'b1;
      if (cs_fall) din_cnt_reg <= 2'h0;
      else if (rx_push & (din_cnt_reg != 2'h3)) din_cnt_reg <= din_cnt_reg + 2'h1;
    end
  end

  // Output bits leave on SCK fall so they are stable at the host's next rise
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_sh_reg   <= `SFE_IDLE_BYTE;
      so_o        <= 1'b0;
      out_cnt_reg <= 3'h0;
    end else begin
      if (cs_fall) out_cnt_reg <= 3'h0;
      else if (tx_take & (out_cnt_reg != 3'h7)) out_cnt_reg <= out_cnt_reg + 3'h1;
      if (tx_load) begin
        tx_sh_reg <= tx_byte;
      end else if (fall_eff & (st_reg == ST_DATA) & out_dir) begin
        so_o      <= tx_sh_reg[7];
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b1};
      end
    end
  end

  // The receiver cannot stall the host, so a full buffer costs the byte and flags it
  sfe_buf #(
    .WIDTH (8),
    .DEPTH (2)
  ) u_rx_buf (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   (rx_byte),
    .in_valid_i  (rx_push),
    .in_ready_o  (buf_in_ready),
    .out_data_o  (rx_data_o),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  AST_SO_FLOAT_DESELECTED: assert property (filt_reg[`SFE_PIN_CS] |-> !so_oe_o)
    else $error("serial output driven while deselected");
  AST_UNKNOWN_IGNORED: assert property (opc_byte && !op_dec.known && !cs_rise
    |=> st_reg == ST_IGNORE ##1 !cmd_start_o)
    else $error("unknown opcode not ignored");
  AST_IGNORE_QUIET: assert property (st_reg == ST_IGNORE && !cs_fall
    |=> $stable(bit_cnt_reg) && $stable(rx_sh_reg) && !tx_ready_o)
    else $error("input accepted after unknown opcode");
  AST_TRUNC_ABORT: assert property (cs_rise && (st_reg == ST_OPCODE || st_reg == ST_HDR)
    |=> cmd_abort_o && !cmd_commit_o)
    else $error("truncated command not discarded");
  AST_CS_END: assert property (cs_rise |=> st_reg == ST_IDLE)
    else $error("chip select rise did not end the command");
  AST_BIT_COUNT: assert property (rise_eff && !cs_fall
    |=> bit_cnt_reg == $past(bit_cnt_reg) + 3'h1)
    else $error("bit counter did not advance on SCK rise");
  AST_HOLD_FREEZE: assert property (hold_act_reg && !cs_fall |=> $stable(bit_cnt_reg))
    else $error("bits counted during hold");
  AST_HOLD_FLOAT: assert property (hold_act_reg |-> !so_oe_o)
    else $error("serial output driven during hold");
  AST_MSB_OUT: assert property (fall_eff && st_reg == ST_DATA && out_dir && !tx_load
    |=> so_o == $past(tx_sh_reg[7]))
    else $error("output bit not taken from the top of the byte");
  AST_STAT_WR_ONE: assert property (cmd_commit_o && cmd_code_o == sfe_pkg::SFE_CMD_STAT_WR
    |-> $past(din_cnt_reg) == 2'h1)
    else $error("status write committed without exactly one byte");
  AST_ERASE_ALIGN: assert property (cmd_start_o && cmd_code_o == sfe_pkg::SFE_CMD_ERASE_4K
    |-> cmd_addr_o[11:0] == 12'h000)
    else $error("small erase address not region aligned");

endmodule : sfe_spi_front_end

`default_nettype wire

// ---- sfe_host.sv ----
// SPI host model: drives chip select, serial clock and serial input, reads SO.
// Assumes its tasks are called from a process clocked by clk_sys_i.
`timescale 1ns/100ps
`default_nettype none
module sfe_host (
  input  wire logic clk_sys_i, // System clock
  input  wire logic so_i,      // Device serial output
  output logic      cs_b_o,    // Chip select, active low
  output logic      sck_o,     // Serial clock
  output logic      si_o       // Device serial input
);
  logic idle_reg;
  initial begin
    cs_b_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    idle_reg = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tick
  task automatic start(input logic mode3);
    idle_reg = mode3;
    sck_o <= mode3;
    tick(4);
    cs_b_o <= 1'b0;
    tick(10);
  endtask : start
  // Half an SCK period is four system clocks, the fastest the front end accepts
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_o <= 1'b0;
      si_o <= tx[i];
      tick(4);
      sck_o <= 1'b1;
      tick(4);
      rx[i] = so_i;
    end
  endtask : xfer
  task automatic stop();
    sck_o <= idle_reg;
    tick(4);
    cs_b_o <= 1'b1;
    si_o <= ~si_o;
    tick(10);
  endtask : stop
endmodule : sfe_host
`default_nettype wire

// ---- serial_flash_spi_command_front_end_tb_top.sv ----
// Self-checking bench of the SPI command front end, host model on the pins.
// Assumes the design files and sfe_host are compiled first.
`timescale 1ns/100ps
`default_nettype none
module serial_flash_spi_command_front_end_tb_top;
  logic clk_sys_i = 1'b0, rst_b_i = 1'b0, rx_rdy = 1'b0, cs_b, sck, si, so, so_oe, st, cm, ab;
  logic rxv, ovr, txr, hold_b = 1'b1;
  logic [7:0] rxd, r;
  logic [15:0] addr, got_addr;
  sfe_pkg::sfe_cmd_t code, got_code;
  int err_count = 0, checks_done = 0, n_cm = 0, n_ab = 0, n_tx = 0;
  sfe_spi_front_end uut (.clk_sys_i, .rst_b_i, .cs_b_i(cs_b), .sck_i(sck), .si_i(si),
    .hold_b_i(hold_b), .so_o(so), .so_oe_o(so_oe), .cmd_code_o(code), .cmd_addr_o(addr),
    .cmd_start_o(st), .cmd_commit_o(cm), .cmd_abort_o(ab), .rx_data_o(rxd), .rx_valid_o(rxv),
    .rx_ready_i(rx_rdy), .rx_overrun_o(ovr), .tx_data_i(8'hA5), .tx_valid_i(1'b1),
    .tx_ready_o(txr));
  // Undriven SO reads high so a floating output never passes for data
  sfe_host host (.clk_sys_i, .so_i(so_oe ? so : 1'b1), .cs_b_o(cs_b), .sck_o(sck), .si_o(si));
  initial forever #25 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    if (st === 1'b1) begin
      got_code <= code;
      got_addr <= addr;
    end
    n_cm <= n_cm + int'(cm === 1'b1);
    n_ab <= n_ab + int'(ab === 1'b1);
    n_tx <= n_tx + int'(txr === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic frame(input logic m3, input logic [7:0] op, input logic [23:0] a,
                       input int na, input int nd);
    host.start(m3);
    host.xfer(op, r);
    for (int i = 0; i < na; i++) host.xfer(a[23-8*i -: 8], r);
    for (int i = 1; i <= nd; i++) host.xfer(8'(17 * i), r);
    host.stop();
  endtask : frame
  task automatic t_read();
    int c = n_cm;
    frame(1'b0, 8'h03, 24'h123456, 3, 1);
    chk("code", 16'(got_code), 16'(sfe_pkg::SFE_CMD_READ));
    chk("addr", got_addr, 16'h3456);
    chk("sodata", 16'(r), 16'h00A5);
    chk("commit", 16'(n_cm - c), 16'h0001);
    chk("so_oe", 16'(so_oe), 16'h0000);
  endtask : t_read
  task automatic rd(input logic m3, input logic [7:0] op, input int na, input int nd,
                    input logic [3:0] cd, input logic [7:0] last, input int takes);
    int c = n_cm;
    int t = n_tx;
    frame(m3, op, 24'h12347F, na, nd);
    chk("code", 16'(got_code), 16'(cd));
    chk("sodata", 16'(r), 16'(last));
    chk("tx_ready", 16'(n_tx - t), 16'(takes));
    chk("commit", 16'(n_cm - c), 16'h0001);
  endtask : rd
  task automatic t_reads();
    rd(1'b1, 8'h0B, 3, 2, 4'h1, 8'hA5, 2);
    chk("addr", got_addr, 16'h347F);
    rd(1'b0, 8'h77, 3, 3, 4'h9, 8'hA5, 2);
    rd(1'b1, 8'h05, 0, 1, 4'hA, 8'hA5, 2);
    rd(1'b0, 8'h9F, 0, 5, 4'hC, 8'hFF, 4);
    rd(1'b1, 8'h15, 0, 3, 4'hD, 8'hFF, 2);
  endtask : t_reads
  task automatic t_cmds();
    int c;
    logic [7:0] ops [10] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h62, 8'h06, 8'h04, 8'hB9, 8'hAB};
    logic [3:0] cd [10] = '{4'h2, 4'h3, 4'h3, 4'h4, 4'h4, 4'h4, 4'h6, 4'h7, 4'hE, 4'hF};
    for (int i = 0; i < 10; i++) begin
      c = n_cm;
      frame(i[0], ops[i], 24'hFFABCD, (i < 3) ? 3 : 0, 0);
      chk("code", 16'(got_code), 16'(cd[i]));
      chk("commit", 16'(n_cm - c), 16'h0001);
      if (i < 3) chk("addr", got_addr, (i > 0) ? 16'h8000 : 16'hA000);
    end
  endtask : t_cmds
  task automatic t_prog();
    frame(1'b0, 8'h02, 24'h001234, 3, 3);
    chk("code", 16'(got_code), 16'(sfe_pkg::SFE_CMD_PROGRAM));
    chk("overrun", 16'(ovr), 16'h0001);
    for (int i = 1; i <= 2; i++) begin
      chk("rxdata", {rxv, 7'h00, rxd}, {1'b1, 7'h00, 8'(17 * i)});
      rx_rdy <= 1'b1;
      @(posedge clk_sys_i);
      rx_rdy <= 1'b0;
      @(posedge clk_sys_i);
    end
    chk("rxvalid", 16'(rxv), 16'h0000);
  endtask : t_prog
  task automatic t_abort();
    int c = n_ab;
    int k = n_cm;
    frame(1'b0, 8'hFF, 24'h030303, 3, 1);
    frame(1'b1, 8'h03, 24'h123456, 2, 0);
    frame(1'b0, 8'h01, 24'h000000, 0, 2);
    chk("abort", 16'(n_ab - c), 16'h0003);
    chk("commit", 16'(n_cm - k), 16'h0000);
  endtask : t_abort
  // A byte clocked while held must vanish, so a stray opcode 00 never reaches the decoder
  task automatic t_hold();
    int c = n_cm;
    host.start(1'b0);
    hold_b <= 1'b0;
    host.tick(8);
    host.xfer(8'h00, r);
    hold_b <= 1'b1;
    host.xfer(8'h06, r);
    host.stop();
    chk("code", 16'(got_code), 16'(sfe_pkg::SFE_CMD_WR_EN));
    frame(1'b0, 8'h01, 24'h000000, 0, 1);
    chk("code", 16'(got_code), 16'(sfe_pkg::SFE_CMD_STAT_WR));
    chk("commit", 16'(n_cm - c), 16'h0002);
  endtask : t_hold
  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_read();
    t_reads();
    t_cmds();
    t_prog();
    t_abort();
    t_hold();
    report_and_stop();
  end
  // About 5200 clocks are needed; the limit leaves a wide margin
  initial begin
    #2000000;
    err_count++;
    report_and_stop();
  end
endmodule : serial_flash_spi_command_front_end_tb_top
`default_nettype wire
